// file: logic/adc_ctrl_consts.vh
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CTRL_ONE     8'h10
`define IDX_CTRL_TWO     8'h11
`define IDX_CMP_VALUE    8'h12
`define IDX_RESULT       8'h13
`define IDX_HIT_STATUS   8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_ACTIVE       7
`define BIT_TRIG_SEL     6
`define BIT_CMP_EN       5
`define BIT_CMP_GT       4
`define BIT_EMPTY        3
`define BIT_FULL         2
`define CHAN_OFF         5'h1F

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_TWO_RESET   8'h08
`define CTRL_ONE_RESET   5'h1F
`define CMP_RESET        12'h000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ          40
`define CONV_TIME_NS     1000
// Cycles of CONV_TIME_NS at CLK_MHZ, sized to 8 bits to match the conversion counter
`define CONV_CYCLES      8'd40

`endif

// file: logic/adc_trigger_compare_control.v
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_consts.vh"

module adc_trigger_compare_control (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [31:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    input  wire        hw_trigger_in,
    input  wire [11:0] sample_data_in,
    output reg         conv_active_out,
    output reg  [4:0]  channel_out,
    output reg         compare_hit_out
);

    localparam [1:0]  FIFO_DEPTH = 2'd3;
    localparam [2:0]  FIFO_COUNT_FULL = 3'd4;
    localparam [7:0]  CONV_LAST = `CONV_CYCLES - 8'd1;
    localparam        ST_IDLE = 1'b0;
    localparam        ST_CONV = 1'b1;

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    function [2:0] reg_sel;
        input [31:0] addr;
        begin
            if (addr[1:0] != 2'b00 || addr[31:10] != 22'h0)
                reg_sel = 3'd0;
            else if (addr[9:2] == `IDX_CTRL_ONE)
                reg_sel = 3'd1;
            else if (addr[9:2] == `IDX_CTRL_TWO)
                reg_sel = 3'd2;
            else if (addr[9:2] == `IDX_CMP_VALUE)
                reg_sel = 3'd3;
            else if (addr[9:2] == `IDX_RESULT)
                reg_sel = 3'd4;
            else if (addr[9:2] == `IDX_HIT_STATUS)
                reg_sel = 3'd5;
            else
                reg_sel = 3'd0;
        end
    endfunction

    reg        state_ff;
    reg [7:0]  cnt_ff;
    reg [4:0]  chan_ff;
    reg        trig_sel_ff;
    reg        cmp_en_ff;
    reg        cmp_gt_ff;
    reg [11:0] cmp_val_ff;
    reg        hit_ff;
    reg        trig_prev_ff;
    reg [11:0] fifo_ff [0:3];
    reg [1:0]  wr_ptr_ff;
    reg [1:0]  rd_ptr_ff;
    reg [2:0]  count_ff;
    reg        rd_had_data_ff;

    wire [2:0] sel      = reg_sel(paddr_in);
    wire       done     = psel_in & penable_in & pready_out;
    wire       wr_done  = done & pwrite_in;
    wire       rd_pop   = done & ~pwrite_in & (sel == 3'd4) & rd_had_data_ff;
    wire       wr_one   = wr_done & (sel == 3'd1);
    wire       fifo_empty = (count_ff == 3'd0);
    wire       fifo_full  = (count_ff == FIFO_COUNT_FULL);
    wire       conv_end   = (state_ff == ST_CONV) & (cnt_ff == CONV_LAST);
    wire       abort_req  = wr_one & (pwdata_in[4:0] == `CHAN_OFF);
    wire       trig_edge  = hw_trigger_in & ~trig_prev_ff;

    // ------------------------------------------------------------
    // Trigger and compare evaluation
    // ------------------------------------------------------------
    reg        start_req;
    reg        cmp_true;
    reg        push;
    always @* begin
        start_req = 1'b0;
        if (wr_one && !trig_sel_ff && !abort_req)
            start_req = 1'b1;
        else if (trig_sel_ff && trig_edge && state_ff == ST_IDLE && chan_ff != `CHAN_OFF)
            start_req = 1'b1;
        if (cmp_gt_ff)
            cmp_true = (sample_data_in >= cmp_val_ff);
        else
            cmp_true = (sample_data_in < cmp_val_ff);
        // Disabled compare passes every result
        push = conv_end & (~cmp_en_ff | cmp_true);
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    // A software start restarts a conversion in flight; hardware triggers are ignored while converting
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff     <= ST_IDLE;
            cnt_ff       <= 8'h00;
            trig_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= hw_trigger_in;
            case (state_ff)
                ST_IDLE: begin
                    if (start_req) begin
                        state_ff <= ST_CONV;
                        cnt_ff   <= 8'h00;
                    end
                end
                default: begin
                    if (abort_req || conv_end) begin
                        state_ff <= ST_IDLE;
                    end else if (start_req) begin
                        cnt_ff <= 8'h00;
                    end else begin
                        cnt_ff <= cnt_ff + 8'h01;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result FIFO
    // ------------------------------------------------------------
    // Results arriving while full are dropped: the oldest unread stay
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr_ff <= 2'd0;
            rd_ptr_ff <= 2'd0;
            count_ff  <= 3'd0;
        end else begin
            if (push && !fifo_full) begin
                fifo_ff[wr_ptr_ff] <= sample_data_in;
                wr_ptr_ff <= (wr_ptr_ff == FIFO_DEPTH) ? 2'd0 : wr_ptr_ff + 2'd1;
            end
            if (rd_pop)
                rd_ptr_ff <= (rd_ptr_ff == FIFO_DEPTH) ? 2'd0 : rd_ptr_ff + 2'd1;
            if ((push && !fifo_full) && !rd_pop)
                count_ff <= count_ff + 3'd1;
            else if (rd_pop && !(push && !fifo_full))
                count_ff <= count_ff - 3'd1;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            chan_ff     <= `CTRL_ONE_RESET;
            trig_sel_ff <= 1'b0;
            cmp_en_ff   <= 1'b0;
            cmp_gt_ff   <= 1'b0;
            cmp_val_ff  <= `CMP_RESET;
            hit_ff      <= 1'b0;
        end else begin
            if (wr_one)
                chan_ff <= pwdata_in[4:0];
            if (wr_done && sel == 3'd2) begin
                trig_sel_ff <= pwdata_in[`BIT_TRIG_SEL];
                cmp_en_ff   <= pwdata_in[`BIT_CMP_EN];
                cmp_gt_ff   <= pwdata_in[`BIT_CMP_GT];
            end
            if (wr_done && sel == 3'd3)
                cmp_val_ff <= pwdata_in[11:0];
            // Set wins over a write-one clear in the same cycle
            if (conv_end && cmp_en_ff && cmp_true)
                hit_ff <= 1'b1;
            else if (wr_done && sel == 3'd5 && pwdata_in[0])
                hit_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // APB answer: one wait state so read data comes from a flop
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            prdata_out     <= 32'h0000_0000;
            pready_out     <= 1'b0;
            pslverr_out    <= 1'b0;
            rd_had_data_ff <= 1'b0;
        end else if (psel_in && penable_in && !pready_out) begin
            pready_out     <= 1'b1;
            pslverr_out    <= (sel == 3'd0);
            rd_had_data_ff <= ~fifo_empty;
            prdata_out     <= 32'h0000_0000;
            if (!pwrite_in) begin
                if (sel == 3'd1)
                    prdata_out <= {27'h0, chan_ff};
                else if (sel == 3'd2)
                    prdata_out <= {24'h0, (state_ff == ST_CONV), trig_sel_ff, cmp_en_ff,
                                   cmp_gt_ff, fifo_empty, fifo_full, 2'b00};
                else if (sel == 3'd3)
                    prdata_out <= {20'h0, cmp_val_ff};
                else if (sel == 3'd4)
                    prdata_out <= fifo_empty ? 32'h0000_0000 : {20'h0, fifo_ff[rd_ptr_ff]};
                else if (sel == 3'd5)
                    prdata_out <= {31'h0, hit_ff};
            end
        end else begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registered status outputs
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            conv_active_out <= 1'b0;
            channel_out     <= `CTRL_ONE_RESET;
            compare_hit_out <= 1'b0;
        end else begin
            conv_active_out <= (state_ff == ST_CONV);
            channel_out     <= chan_ff;
            compare_hit_out <= hit_ff;
        end
    end

endmodule

`default_nettype wire

// file: tb/adc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_props (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic        hw_trigger_in,
    input wire logic [11:0] sample_data_in,
    input wire logic        conv_active_out,
    input wire logic [4:0]  channel_out,
    input wire logic        compare_hit_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0]  sc2_ff;
    logic [11:0] cmp_ff;
    wire         wr_ok = psel_in & penable_in & pready_out & pwrite_in;
    // Shadow of mode bits and compare level; ports alone do not show them
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sc2_ff <= 8'h00;
            cmp_ff <= 12'h000;
        end else if (wr_ok) begin
            if (paddr_in == 32'h44) sc2_ff <= pwdata_in[7:0];
            if (paddr_in == 32'h48) cmp_ff <= pwdata_in[11:0];
        end
    end
    sequence s_sw_go;
        wr_ok && paddr_in == 32'h40 && pwdata_in[4:0] != 5'h1F && !sc2_ff[6] && !conv_active_out;
    endsequence
    sequence s_end(bit gt);
        $fell(conv_active_out) && sc2_ff[5] && sc2_ff[4] == gt;
    endsequence
    property p_busy_hold;
        $rose(conv_active_out) |=> conv_active_out[*8];
    endproperty
    property p_busy_end;
        $rose(conv_active_out) |-> ##[1:45] !conv_active_out;
    endproperty
    property p_sw_start;
        s_sw_go |-> ##[1:3] conv_active_out;
    endproperty
    property p_hw_start;
        $rose(hw_trigger_in) && sc2_ff[6] && !conv_active_out && channel_out != 5'h1F |-> ##[1:4] conv_active_out;
    endproperty
    property p_hit_en;
        $rose(compare_hit_out) |-> sc2_ff[5];
    endproperty
    property p_hit_ge;
        s_end(1'b1) ##0 (sample_data_in >= cmp_ff) |-> ##[0:4] compare_hit_out;
    endproperty
    property p_hit_lt;
        s_end(1'b0) ##0 (sample_data_in < cmp_ff) |-> ##[0:4] compare_hit_out;
    endproperty
    // One wait state, then a single-cycle answer
    property p_ready;
        psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("active flag dropped early");
    a_busy_end: assert property (p_busy_end) else $error("active flag never cleared");
    a_sw_start: assert property (p_sw_start) else $error("no start after write");
    a_hw_start: assert property (p_hw_start) else $error("no start after trigger");
    a_hit_en: assert property (p_hit_en) else $error("hit while compare off");
    a_hit_ge: assert property (p_hit_ge) else $error("missed greater-equal hit");
    a_hit_lt: assert property (p_hit_lt) else $error("missed less-than hit");
    a_ready: assert property (p_ready) else $error("ready timing wrong");
endmodule
bind adc_trigger_compare_control adc_ctrl_props adc_ctrl_props_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .hw_trigger_in(hw_trigger_in),
    .sample_data_in(sample_data_in), .conv_active_out(conv_active_out), .channel_out(channel_out),
    .compare_hit_out(compare_hit_out));
`default_nettype wire

// file: tb/trigger_source.sv
`timescale 1ns/1ps
`default_nettype none
module trigger_source (
    input  wire logic        clk_in,
    input  wire logic        fire_in,
    input  wire logic [3:0]  delay_in,
    input  wire logic [11:0] level_in,
    output wire logic        hw_trigger_out,
    output wire logic [11:0] sample_out
);
    logic [4:0] cnt_ff = 5'h00;
    // Programmable delay so the source can answer promptly or slowly
    always @(posedge clk_in) begin
        if (fire_in) cnt_ff <= {1'b0, delay_in} + 5'h03;
        else if (cnt_ff != 5'h00) cnt_ff <= cnt_ff - 5'h01;
    end
    // Two-cycle trigger pulse; analog level held steady across a conversion
    assign hw_trigger_out = (cnt_ff == 5'h01) || (cnt_ff == 5'h02);
    assign sample_out     = level_in;
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_consts.vh"
module tb_top;
    logic clk_in = 1'b0, rst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, fire = 1'b0;
    logic [31:0] paddr_in = 32'h0, pwdata_in = 32'h0, rd, err;
    logic [3:0]  delay = 4'h0;
    logic [11:0] level = 12'h000;
    wire  [31:0] prdata_out;
    wire         pready_out, pslverr_out, hw_trigger_in, conv_active_out, compare_hit_out;
    wire  [11:0] sample_data_in;
    wire  [4:0]  channel_out;
    int          fails = 0;
    int          comparisons = 0;
    always #12.5 clk_in = ~clk_in;
    adc_trigger_compare_control adc_trigger_compare_control_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .hw_trigger_in(hw_trigger_in), .sample_data_in(sample_data_in), .conv_active_out(conv_active_out),
        .channel_out(channel_out), .compare_hit_out(compare_hit_out));
    trigger_source trigger_source_inst (.clk_in(clk_in), .fire_in(fire), .delay_in(delay), .level_in(level),
        .hw_trigger_out(hw_trigger_in), .sample_out(sample_data_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; an idle cycle first keeps psel from being driven twice in a step
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1 && n < 20) begin
            @(posedge clk_in);
            n++;
        end
        if (pready_out !== 1'b1) fails++;
        rd = prdata_out;
        err = {31'h0, pslverr_out};
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic t_fifo();
        apb(1'b0, 32'h44, 32'h0); chk(rd, 32'h08);
        apb(1'b1, 32'h7C, 32'hFF); chk(err, 32'h1);
        for (int i = 0; i < 4; i++) begin
            level <= 12'h120 + 12'(i);
            apb(1'b1, 32'h40, 32'h03);
            apb(1'b0, 32'h44, 32'h0); chk(rd, i == 0 ? 32'h88 : 32'h80);
            repeat (`CONV_CYCLES + 8) @(posedge clk_in);
        end
        apb(1'b0, 32'h44, 32'h0); chk(rd, 32'h04);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 32'h4C, 32'h0); chk(rd, 32'h120 + i);
            apb(1'b0, 32'h44, 32'h0); chk(rd, i == 3 ? 32'h08 : 32'h00);
        end
        apb(1'b0, 32'h4C, 32'h0); chk(rd, 32'h0);
    endtask
    // Hardware mode: a write does not start, the trigger does, then an abort
    task automatic t_hw();
        apb(1'b1, 32'h44, 32'h40);
        apb(1'b1, 32'h40, 32'h05);
        apb(1'b0, 32'h44, 32'h0); chk(rd, 32'h48);
        chk({27'h0, channel_out}, 32'h05);
        fire <= 1'b1;
        delay <= 4'h6;
        @(posedge clk_in);
        fire <= 1'b0;
        repeat (12) @(posedge clk_in);
        apb(1'b0, 32'h44, 32'h0); chk(rd, 32'hC8);
        apb(1'b1, 32'h40, 32'h1F);
        apb(1'b0, 32'h44, 32'h0); chk(rd, 32'h48);
        chk({27'h0, channel_out}, 32'h1F);
    endtask
    // Only matching results enter the FIFO when compare is on
    task automatic cmp_case(input logic [7:0] sc2, input logic [11:0] lvl, input logic hit);
        apb(1'b1, 32'h44, {24'h0, sc2});
        apb(1'b1, 32'h48, 32'h100);
        level <= lvl;
        apb(1'b1, 32'h40, 32'h02);
        repeat (`CONV_CYCLES + 8) @(posedge clk_in);
        apb(1'b0, 32'h50, 32'h0);
        chk(rd, {31'h0, hit});
        apb(1'b0, 32'h44, 32'h0);
        chk(rd, {24'h0, sc2 | ((hit || !sc2[5]) ? 8'h00 : 8'h08)});
        apb(1'b0, 32'h4C, 32'h0);
        chk(rd, (hit || !sc2[5]) ? {20'h0, lvl} : 32'h0);
        apb(1'b1, 32'h50, 32'h1);
    endtask
    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #(25 * 5000);
        fails++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_fifo();
        t_hw();
        cmp_case(8'h30, 12'h100, 1'b1);
        cmp_case(8'h30, 12'h0FF, 1'b0);
        cmp_case(8'h20, 12'h100, 1'b0);
        cmp_case(8'h20, 12'h0FF, 1'b1);
        cmp_case(8'h00, 12'h0FF, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
